// ===== verilog/uart_top.sv
`timescale 1ns/10ps
// Behaviour
// - reset sets tx buffer empty, end of char and serial out high
// - data strobe clears tx buffer empty
// - holding register moves into idle shift register at once
// - after transfer: serial out and end of char low, buffer empty high
// - frame: start, data, optional parity, stop bits
// - end of char rises after last stop bit held one bit time
// - next character accepted while current frame is sent
// - one control register serves both directions
// - receiver starts on serial input falling edge
// - start re-sampled 8 rx ticks later; abandoned if high
// - edge during high rx clock times from next falling clock edge
// - parity and stop mismatches set error flags
// - no-parity mode keeps parity error low
// - new char while ready set raises overrun
// - receiver takes next char after ready set
// - external reset clears all but control and received data
// - 5 to 8 data bits, odd/even/no parity, 1 or 2 stops
// - rx data and status outputs always driven, with enables on rx_data_oe and status_oe
module uart_top
    import uart_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic               external_reset,
    input  wire logic               tx_clock,
    input  wire logic               rx_clock,
    input  wire logic [DATA_W-1:0]  tx_data_in,
    input  wire logic               data_strobe_n,
    input  wire logic               control_strobe,
    input  wire logic               word_length_bit0,
    input  wire logic               word_length_bit1,
    input  wire logic               two_stop_select,
    input  wire logic               no_parity_select,
    input  wire logic               even_parity_select,
    input  wire logic               rx_word_enable_n,
    input  wire logic               status_out_enable_n,
    input  wire logic               clear_char_ready_n,
    input  wire logic               serial_in,
    output logic                    serial_out,
    output logic                    tx_buffer_empty,
    output logic                    end_of_char,
    output logic [DATA_W-1:0]       rx_data_out,
    output logic                    rx_data_oe,
    output logic                    rx_char_ready_out,
    output logic                    parity_error_out,
    output logic                    framing_error_out,
    output logic                    overrun_out,
    output logic                    tx_buffer_empty_out,
    output logic                    status_oe
);
    import uart_pkg::*;

    // control register, untouched by external reset
    logic [1:0]  wlen, next_wlen;
    logic        two_stop, no_par, even_par;
    logic        next_two_stop, next_no_par, next_even_par;
    logic        cs_d;

    always_comb begin
        next_wlen     = wlen;
        next_two_stop = two_stop;
        next_no_par   = no_par;
        next_even_par = even_par;
        // latch on strobe trailing edge: inputs settled by then
        if (cs_d && !control_strobe) begin
            next_wlen     = {word_length_bit1, word_length_bit0};
            next_two_stop = two_stop_select;
            next_no_par   = no_parity_select;
            next_even_par = even_parity_select;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wlen     <= WLEN_RESET;
            two_stop <= 1'b0;
            no_par   <= 1'b1;
            even_par <= 1'b0;
            cs_d     <= 1'b0;
        end else begin
            wlen     <= next_wlen;
            two_stop <= next_two_stop;
            no_par   <= next_no_par;
            even_par <= next_even_par;
            cs_d     <= control_strobe;
        end
    end

    // transmitter
    frame_state_t       tst, next_tst;
    logic [3:0]         ttick, next_ttick, tbitn, next_tbitn;
    logic [7:0]         hold, next_hold, tsh, next_tsh;
    logic               tpar, next_tpar;
    logic               next_so, next_tx_buffer_empty, next_eoc;
    logic               tclk_d, ds_d, tx_en, load;

    assign tx_en = tclk_d & ~tx_clock;

    always_comb begin
        next_tst   = tst;
        next_ttick = ttick;
        next_tbitn = tbitn;
        next_hold  = hold;
        next_tsh   = tsh;
        next_tpar  = tpar;
        next_so    = serial_out;
        next_tx_buffer_empty  = tx_buffer_empty;
        next_eoc   = end_of_char;
        load       = 1'b0;
        if (!ds_d && data_strobe_n) begin
            next_hold = tx_data_in;
            next_tx_buffer_empty = 1'b0;
        end
        if (tst == ST_IDLE && !tx_buffer_empty) begin
            load       = 1'b1;
            next_tsh   = hold;
            next_tpar  = parity_of(hold, wlen, even_par);
            next_tst   = ST_START;
            next_ttick = 4'h0;
            next_tbitn = 4'h0;
            next_so    = 1'b0;
            next_eoc   = 1'b0;
            next_tx_buffer_empty  = 1'b1;
        end else if (tst != ST_IDLE && tx_en) begin
            next_ttick = ttick + 4'h1;
            if (ttick == LAST_TICK) begin
                case (tst)
                    ST_START: begin
                        next_tst = ST_DATA;
                        next_so  = tsh[0];
                        next_tsh = {1'b0, tsh[7:1]};
                    end
                    ST_DATA: begin
                        next_tbitn = tbitn + 4'h1;
                        if (tbitn + 4'h1 == data_bits(wlen)) begin
                            next_tst = no_par ? ST_STOP1 : ST_PARITY;
                            next_so  = no_par ? 1'b1 : tpar;
                        end else begin
                            next_so  = tsh[0];
                            next_tsh = {1'b0, tsh[7:1]};
                        end
                    end
                    ST_PARITY: begin
                        next_tst = ST_STOP1;
                        next_so  = 1'b1;
                    end
                    ST_STOP1: begin
                        next_tst = two_stop ? ST_STOP2 : ST_IDLE;
                        next_eoc = !two_stop;
                    end
                    ST_STOP2: begin
                        next_tst = ST_IDLE;
                        next_eoc = 1'b1;
                    end
                    default: next_tst = ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        tclk_d <= tx_clock;
        if (!rst_n || external_reset) begin
            tst             <= ST_IDLE;
            ttick           <= 4'h0;
            tbitn           <= 4'h0;
            hold            <= 8'h00;
            tsh             <= 8'h00;
            tpar            <= 1'b0;
            ds_d            <= 1'b1;
            serial_out      <= 1'b1;
            tx_buffer_empty <= 1'b1;
            end_of_char     <= 1'b1;
        end else begin
            tst             <= next_tst;
            ttick           <= next_ttick;
            tbitn           <= next_tbitn;
            hold            <= next_hold;
            tsh             <= next_tsh;
            tpar            <= next_tpar;
            ds_d            <= data_strobe_n;
            serial_out      <= next_so;
            tx_buffer_empty <= next_tx_buffer_empty;
            end_of_char     <= next_eoc;
        end
    end

    logic [7:0] rx_data;
    logic       rx_ready, pe, fe, ovr;

    uart_rx u_rx (
        .sys_clk            (sys_clk),
        .rst_n              (rst_n),
        .external_reset     (external_reset),
        .rx_clock           (rx_clock),
        .serial_in          (serial_in),
        .wlen               (wlen),
        .two_stop           (two_stop),
        .no_par             (no_par),
        .even_par           (even_par),
        .clear_char_ready_n (clear_char_ready_n),
        .rx_data            (rx_data),
        .rx_char_ready      (rx_ready),
        .parity_error       (pe),
        .framing_error      (fe),
        .overrun            (ovr)
    );

    // pins always driven; enables leave on rx_data_oe and status_oe, bus resolution is outside
    assign rx_data_oe          = ~rx_word_enable_n;
    assign rx_data_out         = rx_data;
    assign status_oe           = ~status_out_enable_n;
    assign rx_char_ready_out   = rx_ready;
    assign parity_error_out    = pe;
    assign framing_error_out   = fe;
    assign overrun_out         = ovr;
    assign tx_buffer_empty_out = tx_buffer_empty;

    property p_reset_idle;
        @(posedge sys_clk) disable iff (!rst_n)
        external_reset |=> (serial_out && tx_buffer_empty && end_of_char);
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("line not marking after reset");

    property p_strobe_full;
        @(posedge sys_clk) disable iff (!rst_n || external_reset)
        (!ds_d && data_strobe_n && tst != ST_IDLE) |=> !tx_buffer_empty;
    endproperty
    a_strobe_full: assert property (p_strobe_full)
        else $error("buffer empty stuck after data strobe");

    property p_load;
        @(posedge sys_clk) disable iff (!rst_n || external_reset)
        load |=> (!serial_out && !end_of_char && tx_buffer_empty);
    endproperty
    a_load: assert property (p_load)
        else $error("transfer flags wrong");

    property p_eoc_idle;
        @(posedge sys_clk) disable iff (!rst_n || external_reset)
        $rose(end_of_char) |-> (tst == ST_IDLE && serial_out);
    endproperty
    a_eoc_idle: assert property (p_eoc_idle)
        else $error("end of char raised mid frame");
endmodule

// ===== verilog/uart_pkg.sv
package uart_pkg;
    localparam int           DATA_W       = 8;
    localparam int           OVERSAMPLE   = 16;
    localparam logic [3:0]   CENTER_TICKS = 4'h8;
    localparam logic [3:0]   LAST_TICK    = 4'hf;
    localparam logic [3:0]   MIN_BITS     = 4'h5;
    localparam logic [1:0]   WLEN_RESET   = 2'h3;
    localparam int           CLK_NS       = 4;
    localparam int           CS_HOLD_NS   = 300;
    localparam int           CS_HOLD_CYC  = (CS_HOLD_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_PARITY,
        ST_STOP1,
        ST_STOP2
    } frame_state_t;

    function automatic logic [3:0] data_bits(input logic [1:0] wlen);
        data_bits = MIN_BITS + {2'h0, wlen};
    endfunction

    function automatic logic parity_of(input logic [7:0] d,
                                       input logic [1:0] wlen,
                                       input logic       even);
        logic [7:0] m;
        m = 8'hff >> (4'h3 - {2'h0, wlen});
        parity_of = ^(d & m) ^ ~even;
    endfunction
endpackage

// ===== verilog/uart_rx.sv
`timescale 1ns/10ps
module uart_rx
    import uart_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             external_reset,
    input  wire logic             rx_clock,
    input  wire logic             serial_in,
    input  wire logic [1:0]       wlen,
    input  wire logic             two_stop,
    input  wire logic             no_par,
    input  wire logic             even_par,
    input  wire logic             clear_char_ready_n,
    output logic [DATA_W-1:0]     rx_data,
    output logic                  rx_char_ready,
    output logic                  parity_error,
    output logic                  framing_error,
    output logic                  overrun
);
    import uart_pkg::*;

    frame_state_t     st, next_st;
    logic [3:0]       tick, next_tick;
    logic [3:0]       bitn, next_bitn;
    logic [7:0]       sh, next_sh;
    logic             pbit, next_pbit;
    logic             ferr, next_ferr;
    logic             clk_d, si_d, armed, next_armed;
    logic [7:0]       next_rx_data;
    logic             next_ready, next_pe, next_fe, next_or;
    logic             tick_en, done;

    // sample on falling rx_clock edge, so a start edge seen while high waits
    assign tick_en = clk_d & ~rx_clock;

    always_comb begin
        next_st    = st;
        next_tick  = tick;
        next_bitn  = bitn;
        next_sh    = sh;
        next_pbit  = pbit;
        next_ferr  = ferr;
        next_armed = armed;
        done       = 1'b0;
        case (st)
            ST_IDLE: begin
                if (si_d & ~serial_in) begin
                    next_st   = ST_START;
                    next_tick = 4'h0;
                end
            end
            ST_START: begin
                if (tick_en) begin
                    next_tick = tick + 4'h1;
                    if (tick + 4'h1 == CENTER_TICKS) begin
                        next_tick = 4'h0;
                        next_bitn = 4'h0;
                        next_st   = serial_in ? ST_IDLE : ST_DATA;
                    end
                end
            end
            default: begin
                if (tick_en) begin
                    next_tick = tick + 4'h1;
                    if (tick == LAST_TICK) begin
                        case (st)
                            ST_DATA: begin
                                next_sh = {serial_in, sh[7:1]};
                                next_bitn = bitn + 4'h1;
                                if (bitn + 4'h1 == data_bits(wlen))
                                    next_st = no_par ? ST_STOP1 : ST_PARITY;
                            end
                            ST_PARITY: begin
                                next_pbit = serial_in;
                                next_st   = ST_STOP1;
                            end
                            ST_STOP1: begin
                                next_ferr = ~serial_in;
                                if (two_stop) begin
                                    next_st = ST_STOP2;
                                end else begin
                                    next_st = ST_IDLE;
                                    done    = 1'b1;
                                end
                            end
                            ST_STOP2: begin
                                next_ferr = ferr | ~serial_in;
                                next_st   = ST_IDLE;
                                done      = 1'b1;
                            end
                            default: next_st = ST_IDLE;
                        endcase
                    end
                end
            end
        endcase
        if (next_st == ST_IDLE && st != ST_IDLE)
            next_armed = 1'b1;
    end

    logic [7:0] aligned;
    always_comb begin
        aligned      = sh >> (4'h8 - data_bits(wlen));
        next_rx_data = rx_data;
        next_pe      = parity_error;
        next_fe      = framing_error;
        next_or      = overrun;
        next_ready   = rx_char_ready;
        if (!clear_char_ready_n)
            next_ready = 1'b0;
        if (done) begin
            next_rx_data = aligned;
            next_ready   = 1'b1;
            next_or      = rx_char_ready;
            next_fe      = next_ferr;
            next_pe      = no_par ? 1'b0 :
                           (parity_of(aligned, wlen, even_par) != pbit);
        end
    end

    always_ff @(posedge sys_clk) begin
        clk_d   <= rx_clock;
        si_d    <= serial_in;
        rx_data <= next_rx_data; // held through external reset
        if (!rst_n || external_reset) begin
            st            <= ST_IDLE;
            tick          <= 4'h0;
            bitn          <= 4'h0;
            sh            <= 8'h00;
            pbit          <= 1'b0;
            ferr          <= 1'b0;
            armed         <= 1'b0;
            rx_char_ready <= 1'b0;
            parity_error  <= 1'b0;
            framing_error <= 1'b0;
            overrun       <= 1'b0;
        end else begin
            st            <= next_st;
            tick          <= next_tick;
            bitn          <= next_bitn;
            sh            <= next_sh;
            pbit          <= next_pbit;
            ferr          <= next_ferr;
            armed         <= next_armed;
            rx_char_ready <= next_ready;
            parity_error  <= next_pe;
            framing_error <= next_fe;
            overrun       <= next_or;
        end
    end

    property p_rx_ready_on_done;
        @(posedge sys_clk) disable iff (!rst_n || external_reset)
        done |=> rx_char_ready;
    endproperty
    a_rx_ready_on_done: assert property (p_rx_ready_on_done)
        else $error("char ready not set after frame");

    property p_no_par_pe;
        @(posedge sys_clk) disable iff (!rst_n || external_reset)
        (done && no_par) |=> !parity_error;
    endproperty
    a_no_par_pe: assert property (p_no_par_pe)
        else $error("parity error with parity off");

    property p_overrun;
        @(posedge sys_clk) disable iff (!rst_n || external_reset)
        (done && rx_char_ready) |=> overrun;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun missed");

    property p_start_abort;
        @(posedge sys_clk) disable iff (!rst_n || external_reset)
        (st == ST_START && tick_en && tick == 4'h7 && serial_in)
            |=> st == ST_IDLE;
    endproperty
    a_start_abort: assert property (p_start_abort)
        else $error("false start not abandoned");
endmodule

// ===== testbench/serial_peer.sv
`timescale 1ns/10ps
module serial_peer (
    input  wire logic       sys_clk,
    input  wire logic       tx_clock,
    input  wire logic       rx_clock,
    input  wire logic       line_in,
    input  wire logic [3:0] nbits,
    input  wire logic       par_en,
    input  wire logic       two_stop,
    output logic            line_out,
    output logic            got,
    output logic [7:0]      got_data,
    output logic            got_par,
    output logic            got_stop,
    output logic            sent
);
    logic [11:0] sh;
    int          n;

    initial begin
        line_out = 1'b1;
        got = 1'b0;
        sent = 1'b0;
        got_data = 8'h00;
        got_par = 1'b0;
        got_stop = 1'b0;
    end

    task automatic ticks(input int k);
        repeat (k) @(negedge rx_clock);
        @(negedge sys_clk);
    endtask

    // bit image lsb first: start, data, parity, stops
    task automatic send(input logic [11:0] bits, input int len);
        for (int i = 0; i < len; i++) begin
            line_out = bits[i];
            ticks(16);
        end
        line_out = 1'b1;
        sent = 1'b1;
        @(negedge sys_clk);
        sent = 1'b0;
    endtask

    // short low pulse that must not pass start verification
    task automatic glitch();
        line_out = 1'b0;
        ticks(4);
        line_out = 1'b1;
        ticks(32);
    endtask

    // last sample lands mid stop, so a back-to-back start is not missed
    always begin
        @(negedge line_in);
        n = 2 + int'(nbits) + int'(par_en) + int'(two_stop);
        sh = 12'h000;
        repeat (8) @(negedge tx_clock);
        for (int i = 1; i < n; i++) begin
            repeat (16) @(negedge tx_clock);
            sh[i] = line_in;
        end
        got_data = sh[8:1] & (8'hff >> (4'h8 - nbits));
        got_par = sh[nbits+1];
        got_stop = sh[n-1] & sh[n-1-int'(two_stop)];
        got = 1'b1;
        @(negedge sys_clk);
        got = 1'b0;
    end
endmodule

// ===== testbench/test_uart_top.sv
`timescale 1ns/10ps
module test_uart_top;
    import uart_pkg::*;
    logic        sys_clk, rst_n, external_reset, tx_clock, rx_clock;
    logic [7:0]  tx_data_in, rx_data_out, got_data;
    logic [1:0]  wl;
    logic        data_strobe_n, control_strobe, two_stop_select;
    logic        no_parity_select, even_parity_select, rx_word_enable_n;
    logic        status_out_enable_n, clear_char_ready_n, serial_in;
    logic        serial_out, tx_buffer_empty, end_of_char, rx_data_oe;
    logic        rx_char_ready_out, parity_error_out, framing_error_out;
    logic        overrun_out, status_oe, got, got_par, got_stop, sent;
    logic        pen, ts, tbe_out;
    logic [3:0]  nb;
    logic [8:0]  e9;
    logic [10:0] e11;
    logic [8:0]  exp_tx[$];
    logic [10:0] exp_rx[$];
    int          error_cnt, n_tests, seed;

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // 16x clocks of unrelated rate and phase
    initial begin
        tx_clock = 1'b0;
        forever #8 tx_clock = ~tx_clock;
    end
    initial begin
        rx_clock = 1'b0;
        #3;
        forever #9 rx_clock = ~rx_clock;
    end

    uart_top u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .external_reset(external_reset),
        .tx_clock(tx_clock), .rx_clock(rx_clock), .tx_data_in(tx_data_in),
        .data_strobe_n(data_strobe_n), .control_strobe(control_strobe),
        .word_length_bit0(wl[0]), .word_length_bit1(wl[1]),
        .two_stop_select(two_stop_select),
        .no_parity_select(no_parity_select),
        .even_parity_select(even_parity_select),
        .rx_word_enable_n(rx_word_enable_n),
        .status_out_enable_n(status_out_enable_n),
        .clear_char_ready_n(clear_char_ready_n), .serial_in(serial_in),
        .serial_out(serial_out), .tx_buffer_empty(tx_buffer_empty),
        .end_of_char(end_of_char), .rx_data_out(rx_data_out),
        .rx_data_oe(rx_data_oe), .rx_char_ready_out(rx_char_ready_out),
        .parity_error_out(parity_error_out),
        .framing_error_out(framing_error_out), .overrun_out(overrun_out),
        .tx_buffer_empty_out(tbe_out), .status_oe(status_oe));

    serial_peer u_peer (
        .sys_clk(sys_clk), .tx_clock(tx_clock), .rx_clock(rx_clock),
        .line_in(serial_out), .nbits(nb), .par_en(pen), .two_stop(ts),
        .line_out(serial_in), .got(got), .got_data(got_data),
        .got_par(got_par), .got_stop(got_stop), .sent(sent));

    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        n_tests++;
        if (seen !== want) begin
            error_cnt++;
            $display("ERROR %0t: seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    function automatic logic [7:0] msk(input logic [7:0] d);
        return d & (8'hff >> (4'h8 - nb));
    endfunction

    function automatic logic par(input logic [7:0] d);
        return even_parity_select ? ^d : ~^d;
    endfunction

    task automatic push_tx(input logic [7:0] d);
        exp_tx.push_back({msk(d), par(msk(d))});
    endtask

    // c = {word length, two stop, no parity, even}
    task automatic setup(input logic [4:0] c, input logic tog,
                         input logic [7:0] d);
        @(negedge sys_clk);
        {wl, two_stop_select, no_parity_select, even_parity_select} = c;
        nb = 4'h5 + {2'h0, c[4:3]};
        ts = c[2];
        pen = ~c[1];
        control_strobe = 1'b1;
        if (tog) begin
            tx_data_in = d;
            data_strobe_n = 1'b0;
            push_tx(d);
        end
        repeat (CS_HOLD_CYC + 1) @(negedge sys_clk);
        control_strobe = 1'b0;
        data_strobe_n = 1'b1;
        @(negedge sys_clk);
    endtask

    task automatic load(input logic [7:0] d, input logic idle);
        @(negedge sys_clk);
        tx_data_in = d;
        data_strobe_n = 1'b0;
        push_tx(d);
        @(negedge sys_clk);
        data_strobe_n = 1'b1;
        @(negedge sys_clk);
        chk(tx_buffer_empty, 0);
        if (idle) begin
            @(negedge sys_clk);
            chk({tx_buffer_empty, end_of_char, serial_out}, 3'b100);
        end
    endtask

    task automatic clr();
        @(negedge sys_clk);
        clear_char_ready_n = 1'b0;
        @(negedge sys_clk);
        clear_char_ready_n = 1'b1;
        chk(rx_char_ready_out, 0);
    endtask

    task automatic rx_frame(input logic [7:0] d, input logic bad_par,
                            input logic bad_stop, input logic ovr);
        logic [11:0] b;
        logic [7:0]  m;
        b = 12'hffe;
        m = msk(d);
        for (int i = 0; i < nb; i++) b[1+i] = m[i];
        if (pen) b[1+nb] = par(msk(d)) ^ bad_par;
        if (bad_stop) b[1+nb+pen] = 1'b0;
        exp_rx.push_back({msk(d), pen & bad_par, bad_stop, ovr});
        u_peer.send(b, 2 + int'(nb) + int'(pen) + int'(ts));
    endtask

    task automatic wait_eoc();
        int k;
        k = 0;
        // let a just strobed character reach the shift register first
        repeat (2) @(negedge sys_clk);
        while (end_of_char !== 1'b1 && k < 4000) begin
            @(negedge sys_clk);
            k++;
        end
        chk({end_of_char, serial_out, tx_buffer_empty}, 3'b111);
    endtask

    always @(posedge got) begin
        e9 = exp_tx.pop_front();
        chk(got_data, e9[8:1]);
        if (pen) chk(got_par, e9[0]);
        chk({got_stop, end_of_char}, 2'b10);
    end

    always @(posedge sent) begin
        @(negedge sys_clk);
        e11 = exp_rx.pop_front();
        chk(rx_data_out, e11[10:3]);
        chk({rx_char_ready_out, parity_error_out, framing_error_out,
             overrun_out}, {1'b1, e11[2:0]});
    end

    always @(negedge sys_clk) begin
        if (rst_n) begin
            chk({rx_data_oe, status_oe},
                {~rx_word_enable_n, ~status_out_enable_n});
            chk(tbe_out, tx_buffer_empty);
        end
        {rx_word_enable_n, status_out_enable_n} = 2'($random(seed));
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        error_cnt++;
        $display("ERROR %0t: watchdog expired", $time);
        test_done();
    end

    initial begin
        seed = 32'h9486;
        error_cnt = 0;
        n_tests = 0;
        rst_n = 1'b0;
        external_reset = 1'b0;
        tx_data_in = 8'h00;
        data_strobe_n = 1'b1;
        control_strobe = 1'b0;
        {wl, two_stop_select, no_parity_select, even_parity_select} = 5'h1c;
        rx_word_enable_n = 1'b1;
        status_out_enable_n = 1'b1;
        clear_char_ready_n = 1'b1;
        nb = 4'h8;
        pen = 1'b0;
        ts = 1'b0;
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        chk({serial_out, tx_buffer_empty, end_of_char, rx_char_ready_out},
            4'he);
        // one shared format per pass, both directions at once
        for (int i = 0; i < 4; i++) begin
            setup({i[1:0], i[0], i == 2, i[1]}, 1'b0, 8'h00);
            fork
                begin
                    load(8'($random(seed)), 1'b1);
                    load(8'($random(seed)), 1'b0);
                end
                begin
                    clr();
                    rx_frame(8'($random(seed)), 1'b0, 1'b0, 1'b0);
                end
            join
            wait_eoc();
            $display("format %0d done", i);
        end
        setup(5'h18, 1'b1, 8'h5a);
        wait_eoc();
        $display("joint strobe done");
        clr();
        rx_frame(8'h3c, 1'b1, 1'b0, 1'b0);
        clr();
        rx_frame(8'hc3, 1'b0, 1'b1, 1'b0);
        clr();
        u_peer.glitch();
        chk(rx_char_ready_out, 0);
        rx_frame(8'ha5, 1'b0, 1'b0, 1'b0);
        rx_frame(8'h96, 1'b0, 1'b0, 1'b1);
        $display("receive errors done");
        @(negedge sys_clk);
        external_reset = 1'b1;
        @(negedge sys_clk);
        external_reset = 1'b0;
        @(negedge sys_clk);
        chk({rx_char_ready_out, parity_error_out, framing_error_out,
             overrun_out, serial_out, tx_buffer_empty, end_of_char},
            8'h07);
        chk(rx_data_out, 8'h96);
        load(8'h81, 1'b1);
        wait_eoc();
        $display("external reset done");
        test_done();
    end
endmodule
